// ==== src/sir_rate_gen.v ====
// Purpose: Operation clock enable and serial bit rate tick for one simplified I2C channel.
// Assumes: Single 200 MHz clock; timer interval event is a one-cycle pulse on the same clock.
//          The register port never waits; read data stand one cycle after the read strobe.
// Notes:   The operation clock is a one-cycle enable, not a derived clock.
//          Reserved prescale codes stop the operation clock instead of guessing a rate.
//          Start, address, data and stop sequencing live outside this block.
`timescale 1ns/1ps
`include "sir_regs.vh"

module sir_rate_gen (
    input  wire                    i_clk_sys,
    input  wire                    i_rst_b,
    input  wire [`SIR_ADDR_W-1:0]  i_addr,
    input  wire [15:0]             i_wdata,
    input  wire                    i_wr,
    input  wire                    i_rd,
    input  wire                    i_timer_interval_event,
    output reg  [15:0]             o_rdata,
    output reg                     o_channel_operation_clock,
    output reg                     o_bit_tick,
    output reg                     o_serial_clock
);

    // ======================================================================
    // State and decode signals
    // ======================================================================
    reg  [7:0]  prescale_select_reg;
    reg         clock_source_select;
    reg  [6:0]  rate_divisor;
    reg         channel_enable;
    reg  [10:0] prescale_count;
    reg  [3:0]  sel_code;
    reg  [6:0]  divide_count;
    reg         tick_phase;
    reg  [15:0] next_rdata;
    reg         next_op_clk;
    reg  [6:0]  next_divide_count;
    reg         next_tick_phase;
    reg         next_serial_clock;
    reg         next_bit_tick;
    wire [3:0]  next_sel_code;
    wire [10:0] low_ones;
    wire        wr_prescale;
    wire        wr_mode;
    wire        wr_divisor;
    wire        code_is_event;
    wire        code_is_divided;
    wire        half_done;
    genvar      g;

    // ======================================================================
    // Register writes
    // ======================================================================
    assign wr_prescale = i_wr && (i_addr == `SIR_OFF_PRESCALE);
    assign wr_mode     = i_wr && (i_addr == `SIR_OFF_MODE);
    assign wr_divisor  = i_wr && (i_addr == `SIR_OFF_DIVISOR);

    // Settings may be rewritten at any time; the channel does not fence them,
    // so software has to stop it before it moves the base clock.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            prescale_select_reg <= `SIR_RST_PRESCALE;
        end else if (wr_prescale) begin
            prescale_select_reg <= i_wdata[`SIR_UP_MSB:`SIR_LOW_LSB];
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            clock_source_select <= `SIR_RST_CKS;
            channel_enable      <= `SIR_RST_ENABLE;
        end else if (wr_mode) begin
            clock_source_select <= i_wdata[`SIR_CKS_BIT];
            channel_enable      <= i_wdata[`SIR_EN_BIT];
        end
    end

    // A divisor of zero is stored as written: keeping it out is left to software.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rate_divisor <= `SIR_RST_DIVISOR;
        end else if (wr_divisor) begin
            rate_divisor <= i_wdata[`SIR_DIV_MSB:`SIR_DIV_LSB];
        end
    end

    // ======================================================================
    // Register reads
    // ======================================================================
    always @* begin
        next_rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `SIR_OFF_PRESCALE: next_rdata = {8'h00, prescale_select_reg};
                `SIR_OFF_MODE:     next_rdata = {clock_source_select, 14'h0000, channel_enable};
                `SIR_OFF_DIVISOR:  next_rdata = {rate_divisor, 9'h000};
                `SIR_OFF_STATUS:   next_rdata = {13'h0000, code_is_event, tick_phase, channel_enable};
                default:           next_rdata = 16'h0000;
            endcase
        end
    end

    // Read data stand one cycle behind the read strobe, for as long as it is held, and then return to zero.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // ======================================================================
    // Operation clock selection
    // ======================================================================
    assign next_sel_code = clock_source_select ? prescale_select_reg[`SIR_UP_MSB:`SIR_UP_LSB]
                                               : prescale_select_reg[`SIR_LOW_MSB:`SIR_LOW_LSB];

    // The code is registered so that the selection below sees one stable value per cycle.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            sel_code <= 4'h0;
        end else begin
            sel_code <= next_sel_code;
        end
    end

    assign code_is_event   = (sel_code == `SIR_CODE_EVENT);
    assign code_is_divided = (sel_code <= `SIR_CODE_MAX);

    // The prescaler runs freely, so a new code takes effect at once; the price is
    // that the first operation clock after a change may come early.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            prescale_count <= 11'h000;
        end else begin
            prescale_count <= prescale_count + 11'h001;
        end
    end

    // Bit g counts as one when it lies at or above the code; a division by 2^code
    // then fires when all eleven bits agree.
    generate
        for (g = 0; g < 11; g = g + 1) begin : gen_low_ones
            assign low_ones[g] = (g >= sel_code) || prescale_count[g];
        end
    endgenerate

    // Reserved codes 12 to 14 fall through both branches and give no clock.
    always @* begin
        next_op_clk = 1'b0;
        if (code_is_event) begin
            next_op_clk = i_timer_interval_event;
        end else if (code_is_divided) begin
            next_op_clk = &low_ones;
        end
    end

    // ======================================================================
    // Operation clock output
    // ======================================================================
    // Gated by the enable so that a stopped channel shows no clock at all.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_channel_operation_clock <= 1'b0;
        end else begin
            o_channel_operation_clock <= next_op_clk & channel_enable;
        end
    end

    // ======================================================================
    // Bit rate divider
    // ======================================================================
    // Each half period spans divisor plus one operation clocks, so a full bit
    // takes twice that; a divisor of zero would break the quarter-rate limit.
    assign half_done = (divide_count >= rate_divisor);

    always @* begin
        next_divide_count = divide_count;
        next_tick_phase   = tick_phase;
        next_serial_clock = o_serial_clock;
        next_bit_tick     = 1'b0;
        if (o_channel_operation_clock) begin
            if (half_done) begin
                next_divide_count = 7'h00;
                next_tick_phase   = ~tick_phase;
                next_serial_clock = tick_phase;
                next_bit_tick     = tick_phase;
            end else begin
                next_divide_count = divide_count + 7'h01;
            end
        end
    end

    // Disabling the channel parks the serial clock high and restarts the count.
    always @(posedge i_clk_sys) begin
        if (!i_rst_b || !channel_enable) begin
            divide_count   <= 7'h00;
            tick_phase     <= 1'b0;
            o_bit_tick     <= 1'b0;
            o_serial_clock <= 1'b1;
        end else begin
            divide_count   <= next_divide_count;
            tick_phase     <= next_tick_phase;
            o_bit_tick     <= next_bit_tick;
            o_serial_clock <= next_serial_clock;
        end
    end

endmodule

// ==== include/sir_regs.vh ====
// Purpose: Register offsets, field positions and reset values of the I2C rate generator.
// Assumes: Plain register port with word offsets as byte addresses.
// Notes:   Included by the rate generator design file only.
`ifndef SIR_REGS_VH
`define SIR_REGS_VH

// ==========================================================================
// Register offsets
// ==========================================================================
`define SIR_ADDR_W          8
`define SIR_OFF_PRESCALE    8'h00
`define SIR_OFF_MODE        8'h04
`define SIR_OFF_DIVISOR     8'h08
`define SIR_OFF_STATUS      8'h0c

// ==========================================================================
// Field positions and codes
// ==========================================================================
`define SIR_LOW_MSB         3
`define SIR_LOW_LSB         0
`define SIR_UP_MSB          7
`define SIR_UP_LSB          4
`define SIR_CKS_BIT         15
`define SIR_EN_BIT          0
`define SIR_DIV_MSB         15
`define SIR_DIV_LSB         9
`define SIR_CODE_EVENT      4'hf
`define SIR_CODE_MAX        4'hb

// ==========================================================================
// Reset values
// ==========================================================================
`define SIR_RST_PRESCALE    8'h00
`define SIR_RST_CKS         1'b0
`define SIR_RST_DIVISOR     7'h01
`define SIR_RST_ENABLE      1'b0

`endif

// ==== sim/sir_slave_model.sv ====
// Purpose: Serial bus slave that counts clock rises.
// Assumes: Same clock as the design.
// Notes:   It only listens, so the bus is never loaded.
`timescale 1ns/1ps
module sir_slave_model (
    input  wire        i_clk_sys,
    input  wire        i_scl,
    output reg  [15:0] o_bits
);
    reg last = 1'b1;
    initial o_bits = 16'h0000;
    always @(posedge i_clk_sys) begin
        last <= i_scl;
        if (i_scl && !last) begin
            o_bits <= o_bits + 16'h0001;
        end
    end
endmodule

// ==== sim/sir_rate_gen_assertions.sv ====
// Purpose: Port checks of the rate generator.
// Assumes: One clock, synchronous reset.
// Notes:   Readback checks need a write then a read.
`timescale 1ns/1ps
module sir_rate_gen_assertions (
    input wire        i_clk_sys,
    input wire        i_rst_b,
    input wire [7:0]  i_addr,
    input wire [15:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire        i_timer_interval_event,
    input wire [15:0] o_rdata,
    input wire        o_channel_operation_clock,
    input wire        o_bit_tick,
    input wire        o_serial_clock
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    property p_rdz; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("rdata not idle");
    property p_div; i_wr && i_addr == 8'h08 ##1 i_rd && i_addr == 8'h08 |=> o_rdata[15:9] == $past(i_wdata[15:9], 2); endproperty
    a_div: assert property (p_div) else $error("divisor");
    property p_ps; i_wr && i_addr == 8'h00 ##1 i_rd && i_addr == 8'h00 |=> o_rdata[7:0] == $past(i_wdata[7:0], 2); endproperty
    a_ps: assert property (p_ps) else $error("prescale");
    property p_md; i_wr && i_addr == 8'h04 ##1 i_rd && i_addr == 8'h04 |=> o_rdata[15] == $past(i_wdata[15], 2); endproperty
    a_md: assert property (p_md) else $error("source select");
    property p_tr; o_bit_tick |-> $rose(o_serial_clock); endproperty
    a_tr: assert property (p_tr) else $error("tick");
    property p_gap; o_bit_tick |=> (!o_bit_tick) [*3]; endproperty
    a_gap: assert property (p_gap) else $error("tick gap");
    property p_fn; $fell(o_serial_clock) |-> !o_bit_tick; endproperty
    a_fn: assert property (p_fn) else $error("tick on fall");
    property p_hf; $fell(o_serial_clock) |=> !$rose(o_serial_clock); endproperty
    a_hf: assert property (p_hf) else $error("half period");
endmodule
bind sir_rate_gen sir_rate_gen_assertions sir_rate_gen_assertions_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_timer_interval_event(i_timer_interval_event),
    .o_rdata(o_rdata), .o_channel_operation_clock(o_channel_operation_clock), .o_bit_tick(o_bit_tick),
    .o_serial_clock(o_serial_clock));

// ==== sim/sir_rate_gen_bench.sv ====
// Purpose: Register and bit period checks.
// Assumes: Timer event every 7 cycles.
// Notes:   The third tick period is measured.
`timescale 1ns/1ps
module sir_rate_gen_bench;
    reg c = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] a = 8'h00;
    reg [15:0] d = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg ev = 1'b0;
    reg hung = 1'b0;
    reg [2:0] ec = 3'h0;
    wire [15:0] q, bits;
    wire op, tk, scl;
    integer fail_count = 0, n_checks = 0, n, k;
    always #2.5 c = ~c; // The base clock is reselected in each run without a stop, so the first two periods are not checked.
    always @(posedge c) begin
        ec <= (ec == 3'h6) ? 3'h0 : ec + 3'h1;
        ev <= (ec == 3'h6);
    end
    sir_rate_gen sir_rate_gen_inst (.i_clk_sys(c), .i_rst_b(rst_b), .i_addr(a), .i_wdata(d), .i_wr(wr), .i_rd(rd),
        .i_timer_interval_event(ev), .o_rdata(q), .o_channel_operation_clock(op), .o_bit_tick(tk), .o_serial_clock(scl));
    sir_slave_model sir_slave_model_inst (.i_clk_sys(c), .i_scl(scl), .o_bits(bits));
    task automatic chk(input [31:0] s, input [31:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic w(input [7:0] ad, input [15:0] dt);
        @(posedge c);
        a <= ad;
        d <= dt;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask
    task automatic r(input [7:0] ad, input [15:0] e);
        @(posedge c);
        a <= ad;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge c);
        rd <= 1'b0;
        #1 chk(q, e);
    endtask
    // The first two periods may still carry the old setting.
    task automatic run(input [7:0] ps, input [15:0] md, input [6:0] dv, input integer e);
        w(8'h00, {8'h00, ps});
        r(8'h00, {8'h00, ps});
        w(8'h04, md);
        r(8'h04, md);
        w(8'h08, {dv, 9'h000});
        r(8'h08, {dv, 9'h000});
        for (k = 0; k < 3 && !hung; k++) begin
            n = 0;
            @(posedge c);
            #1;
            while (tk !== 1'b1 && n < 20000) begin
                @(posedge c);
                #1 n++;
            end
            if (n >= 20000) begin
                fail_count++;
                hung = 1'b1;
            end
        end
        chk(n + 1, e);
    endtask
    initial begin
        repeat (2) @(posedge c);
        rst_b <= 1'b1;
        r(8'h08, 16'h0200);
        r(8'h10, 16'h0000);
        run(8'h00, 16'h0001, 7'h01, 4);
        run(8'h02, 16'h0001, 7'h03, 32);
        run(8'h1b, 16'h8001, 7'h02, 12);
        run(8'h00, 16'h0001, 7'h7f, 256);
        run(8'h0b, 16'h0001, 7'h01, 8192);
        run(8'h0f, 16'h0001, 7'h01, 28);
        run(8'hf0, 16'h8001, 7'h18, 350);
        chk(bits > 16'h0000, 32'h1);
        w(8'h00, 16'h00cc);
        r(8'h00, 16'h00cc);
        repeat (8) @(posedge c);
        k = bits;
        n = 0;
        repeat (64) begin
            @(posedge c);
            #1 n += op;
        end
        chk(n, 0);
        chk(bits, k);
        give_verdict;
    end
endmodule
